// File: shared/lpm_pkg.sv
// constants for the low power mode and reset controller
package lpm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_CLK = 8'h08;
    localparam logic [7:0] OFS_RSRC = 8'h0C;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_DSLEEP = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;
    // clock config fields
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_SEL_LSB = 8;
    localparam int CLK_PLL0_BIT = 10;
    localparam int CLK_PLL1_BIT = 11;
    localparam int CLK_CONN_BIT = 12;
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [7:0] CLKDIV_RST = 8'h00;
    // protection levels
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_ONE = 2'h1;
    localparam logic [1:0] PROT_TWO = 2'h2;
    localparam logic [1:0] PROT_THREE = 2'h3;
    // bootloader command sets
    localparam logic [1:0] BL_FULL = 2'h0;
    localparam logic [1:0] BL_LIMITED = 2'h1;
    localparam logic [1:0] BL_REDUCED = 2'h2;
    localparam logic [1:0] BL_NONE = 2'h3;
    // timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int IRC_START_NS = 60000;
    localparam int IRC_START_CYC = (IRC_START_NS * 1000) / CLK_PERIOD_PS;
    localparam int IRC_FREQ_MHZ = 12;
    localparam int FLASH_START_US = 100;
    localparam logic [15:0] FLASH_START_TICKS = 16'(IRC_FREQ_MHZ * FLASH_START_US);
    localparam logic [15:0] IRC_RESUME_TICKS = 16'h0004;
    localparam logic [15:0] OSC_RESUME_TICKS = 16'h1000;
    localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;
    // state encoding
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_DSLEEP = 6'h02,
        ST_PDOWN = 6'h04,
        ST_DPD = 6'h08,
        ST_IRC_START = 6'h10,
        ST_RESUME = 6'h20
    } lpm_state_t;
endpackage

// File: logic/lpm_ctrl.sv
// low power mode sequencer, reset combiner and code protection gate
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - deep sleep stops clocks, gates rc output, holds pins and state
// - deep sleep turns off and disconnects the pll, clears dividers
// - deep sleep wakes on any enabled wake source interrupt
// - any enabled pending interrupt or a reset ends deep sleep
// - rc clock source wake resumes after four rc cycles
// - main oscillator wake resumes after 4096 oscillator cycles
// - power-down also removes rc and flash power
// - power-down stops both plls, resets clock select and dividers
// - watchdog and rtc keep running through power-down
// - power-down wake waits rc start-up then four rc cycles
// - flash timer counts rc cycles for 100 us, blocking flash
// - software reprograms pll and dividers after wake
// - deep power-down entered only by rtc request, core, rc and flash power off
// - deep power-down left only by a chip reset (any reset source) or rtc alarm
// - irq controller mask latched on entry decides wake
// - chip reset from pin, watchdog, power-on and brownout
// - internal reset held until pin, oscillator, count, flash ready
// - fetch starts at address zero after reset release
// - first brownout stage raises interrupt and status bit
// - second brownout stage raises chip reset
// - level one blocks debug, limited bootloader, sector zero locked
// - level two reduced bootloader, level three blocks all
module lpm_ctrl #(
    parameter int NIRQ = 16,
    parameter int RST_HOLD = 16,
    parameter int IRC_START = lpm_pkg::IRC_START_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_req_i,
    input wire logic [NIRQ-1:0] irq_pend_i,
    input wire logic [NIRQ-1:0] irq_mask_i,
    input wire logic rtc_dpd_req_i,
    input wire logic rtc_alarm_i,
    input wire logic irc_tick_i,
    input wire logic osc_tick_i,
    input wire logic osc_ok_i,
    input wire logic flash_init_done_i,
    input wire logic rst_pin_i,
    input wire logic wdt_rst_i,
    input wire logic por_i,
    input wire logic bod_low_i,
    input wire logic bod_crit_i,
    input wire logic wdt_run_i,
    input wire logic rtc_en_i,
    input wire logic [1:0] prot_level_i,
    output logic clocks_en_o,
    output logic osc_en_o,
    output logic irc_out_en_o,
    output logic irc_pwr_o,
    output logic flash_pwr_o,
    output logic flash_access_o,
    output logic core_pwr_o,
    output logic pins_hold_o,
    output logic cpu_run_o,
    output logic wdt_keep_o,
    output logic rtc_keep_o,
    output logic pll0_en_o,
    output logic pll1_en_o,
    output logic pll_conn_o,
    output logic [1:0] clk_sel_o,
    output logic [7:0] clk_div_o,
    output logic chip_rst_o,
    output logic [31:0] boot_addr_o,
    output logic bod_irq_o,
    output logic dbg_allow_o,
    output logic [1:0] bl_cmdset_o,
    output logic sector0_lock_o,
    output logic override_pin_en_o
);
    // ******************************
    // reset combining
    // ******************************
    logic [15:0] hold_cnt_r;
    logic chip_rst_r;
    logic [3:0] rsrc_r;
    logic [1:0] prot_r;
    logic src_rst;
    assign src_rst = rst_i | rst_pin_i | wdt_rst_i | por_i | bod_crit_i;

    always_ff @(posedge clk_i) begin
        if (src_rst) begin
            hold_cnt_r <= 16'h0000;
            chip_rst_r <= 1'b1;
        end else if (chip_rst_r) begin
            if (hold_cnt_r < 16'(RST_HOLD)) begin
                hold_cnt_r <= hold_cnt_r + 16'h0001;
            end
            if (hold_cnt_r >= 16'(RST_HOLD) && osc_ok_i && flash_init_done_i) begin
                chip_rst_r <= 1'b0;
            end
        end
    end

    // sticky record of reset causes, cleared by writing ones
    logic bus_wr;
    logic [7:0] bus_adr;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsrc_r <= 4'h0;
        end else begin
            rsrc_r <= (rsrc_r & ~((bus_wr && bus_adr == lpm_pkg::OFS_RSRC)
                ? wb_dat_i[3:0] : 4'h0)) | {bod_crit_i, por_i, wdt_rst_i, rst_pin_i};
        end
    end

    // protection level caught while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_r <= lpm_pkg::PROT_THREE;
        end else if (chip_rst_r) begin
            prot_r <= prot_level_i;
        end
    end

    // ******************************
    // register bus
    // ******************************
    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] mode_r;
    logic src_osc_r;
    logic [7:0] div_r;
    logic [1:0] sel_r;
    logic pll0_r;
    logic pll1_r;
    logic conn_r;
    lpm_pkg::lpm_state_t st_r;
    logic flash_ok_r;
    logic bod_r;
    assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
    assign bus_adr = wb_adr_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            case (wb_adr_i)
                lpm_pkg::OFS_CTRL: begin
                    dat_r <= {29'h0, src_osc_r, mode_r};
                end
                lpm_pkg::OFS_STAT: begin
                    dat_r <= {22'h0, prot_r, bod_r, flash_ok_r, st_r};
                end
                lpm_pkg::OFS_CLK: begin
                    dat_r <= {19'h0, conn_r, pll1_r, pll0_r, sel_r, div_r};
                end
                lpm_pkg::OFS_RSRC: begin
                    dat_r <= {28'h0, rsrc_r};
                end
                default: begin
                    dat_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs);
        return bus_wr && bus_adr == ofs && wb_sel_i[0];
    endfunction

    // ******************************
    // wake sequencer
    // ******************************
    logic [NIRQ-1:0] wmask_r;
    logic [15:0] cnt_r;
    logic [15:0] fcnt_r;
    logic from_pd_r;
    logic wake_irq;
    logic enter;
    assign wake_irq = |(irq_pend_i & wmask_r);
    assign enter = sleep_req_i && mode_r != lpm_pkg::MODE_RUN;

    always_ff @(posedge clk_i) begin
        if (chip_rst_r) begin
            mode_r <= lpm_pkg::MODE_RUN;
            src_osc_r <= 1'b0;
        end else if (wr_hit(lpm_pkg::OFS_CTRL)) begin
            mode_r <= wb_dat_i[lpm_pkg::CTRL_MODE_LSB +: 2];
            src_osc_r <= wb_dat_i[lpm_pkg::CTRL_SRC_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (chip_rst_r) begin
            st_r <= lpm_pkg::ST_RUN;
            wmask_r <= '0;
            cnt_r <= 16'h0000;
            from_pd_r <= 1'b0;
        end else begin
            case (st_r)
                lpm_pkg::ST_RUN: begin
                    cnt_r <= 16'h0000;
                    if (rtc_dpd_req_i) begin
                        st_r <= lpm_pkg::ST_DPD;
                    end else if (enter) begin
                        wmask_r <= irq_mask_i;
                        from_pd_r <= mode_r == lpm_pkg::MODE_PDOWN;
                        st_r <= mode_r == lpm_pkg::MODE_PDOWN
                            ? lpm_pkg::ST_PDOWN : lpm_pkg::ST_DSLEEP;
                    end
                end
                lpm_pkg::ST_DSLEEP: begin
                    if (wake_irq) begin
                        st_r <= lpm_pkg::ST_RESUME;
                    end
                end
                lpm_pkg::ST_PDOWN: begin
                    if (wake_irq) begin
                        st_r <= lpm_pkg::ST_IRC_START;
                    end
                end
                lpm_pkg::ST_DPD: begin
                    if (rtc_alarm_i) begin
                        st_r <= lpm_pkg::ST_RESUME;
                    end
                end
                lpm_pkg::ST_IRC_START: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r >= 16'(IRC_START - 1)) begin
                        cnt_r <= 16'h0000;
                        st_r <= lpm_pkg::ST_RESUME;
                    end
                end
                lpm_pkg::ST_RESUME: begin
                    if ((src_osc_r && !from_pd_r) ? osc_tick_i : irc_tick_i) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                    if (cnt_r >= ((src_osc_r && !from_pd_r)
                        ? lpm_pkg::OSC_RESUME_TICKS
                        : lpm_pkg::IRC_RESUME_TICKS)) begin
                        st_r <= lpm_pkg::ST_RUN;
                        from_pd_r <= 1'b0;
                    end
                end
                default: begin
                    st_r <= lpm_pkg::ST_RUN;
                end
            endcase
        end
    end

    // flash start-up timer, started by a power-down wake
    always_ff @(posedge clk_i) begin
        if (chip_rst_r) begin
            fcnt_r <= 16'h0000;
            flash_ok_r <= 1'b1;
        end else if (st_r == lpm_pkg::ST_PDOWN) begin
            fcnt_r <= 16'h0000;
            flash_ok_r <= 1'b0;
        end else if (!flash_ok_r && st_r != lpm_pkg::ST_IRC_START && irc_tick_i) begin
            fcnt_r <= fcnt_r + 16'h0001;
            if (fcnt_r >= lpm_pkg::FLASH_START_TICKS - 16'h0001) begin
                flash_ok_r <= 1'b1;
            end
        end
    end

    // ******************************
    // clock configuration
    // ******************************
    always_ff @(posedge clk_i) begin
        if (chip_rst_r) begin
            div_r <= lpm_pkg::CLKDIV_RST;
            sel_r <= lpm_pkg::CLKSEL_RST;
            pll0_r <= 1'b0;
            pll1_r <= 1'b0;
            conn_r <= 1'b0;
        end else if (st_r == lpm_pkg::ST_RUN && enter) begin
            div_r <= lpm_pkg::CLKDIV_RST;
            pll0_r <= 1'b0;
            pll1_r <= 1'b0;
            conn_r <= 1'b0;
            if (mode_r == lpm_pkg::MODE_PDOWN) begin
                sel_r <= lpm_pkg::CLKSEL_RST;
            end
        end else if (wr_hit(lpm_pkg::OFS_CLK) && wb_sel_i[1]) begin
            div_r <= wb_dat_i[lpm_pkg::CLK_DIV_LSB +: 8];
            sel_r <= wb_dat_i[lpm_pkg::CLK_SEL_LSB +: 2];
            pll0_r <= wb_dat_i[lpm_pkg::CLK_PLL0_BIT];
            pll1_r <= wb_dat_i[lpm_pkg::CLK_PLL1_BIT];
            conn_r <= wb_dat_i[lpm_pkg::CLK_CONN_BIT];
        end
    end

    // ******************************
    // registered outputs
    // ******************************
    logic low;
    logic pd;
    assign low = st_r == lpm_pkg::ST_DSLEEP || st_r == lpm_pkg::ST_PDOWN
        || st_r == lpm_pkg::ST_DPD;
    assign pd = st_r == lpm_pkg::ST_PDOWN || st_r == lpm_pkg::ST_IRC_START && from_pd_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clocks_en_o <= 1'b0;
            osc_en_o <= 1'b0;
            irc_out_en_o <= 1'b0;
            irc_pwr_o <= 1'b1;
            flash_pwr_o <= 1'b1;
            flash_access_o <= 1'b0;
            core_pwr_o <= 1'b1;
            pins_hold_o <= 1'b0;
            cpu_run_o <= 1'b0;
            wdt_keep_o <= 1'b0;
            rtc_keep_o <= 1'b0;
            bod_r <= 1'b0;
        end else begin
            clocks_en_o <= !low;
            osc_en_o <= !low && src_osc_r;
            irc_out_en_o <= !low;
            irc_pwr_o <= !pd && st_r != lpm_pkg::ST_DPD;
            flash_pwr_o <= !pd && st_r != lpm_pkg::ST_DPD;
            flash_access_o <= flash_ok_r && st_r == lpm_pkg::ST_RUN && !chip_rst_r;
            core_pwr_o <= st_r != lpm_pkg::ST_DPD;
            pins_hold_o <= low;
            cpu_run_o <= st_r == lpm_pkg::ST_RUN && !chip_rst_r;
            wdt_keep_o <= wdt_run_i;
            rtc_keep_o <= rtc_en_i;
            bod_r <= bod_low_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_allow_o <= 1'b0;
            bl_cmdset_o <= lpm_pkg::BL_NONE;
            sector0_lock_o <= 1'b1;
            override_pin_en_o <= 1'b0;
        end else begin
            dbg_allow_o <= prot_r == lpm_pkg::PROT_NONE;
            case (prot_r)
                lpm_pkg::PROT_ONE: bl_cmdset_o <= lpm_pkg::BL_LIMITED;
                lpm_pkg::PROT_TWO: bl_cmdset_o <= lpm_pkg::BL_REDUCED;
                lpm_pkg::PROT_THREE: bl_cmdset_o <= lpm_pkg::BL_NONE;
                default: bl_cmdset_o <= lpm_pkg::BL_FULL;
            endcase
            sector0_lock_o <= prot_r == lpm_pkg::PROT_ONE;
            override_pin_en_o <= prot_r != lpm_pkg::PROT_THREE;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign chip_rst_o = chip_rst_r;
    assign boot_addr_o = lpm_pkg::BOOT_VECTOR;
    assign bod_irq_o = bod_r;
    assign pll0_en_o = pll0_r;
    assign pll1_en_o = pll1_r;
    assign pll_conn_o = conn_r;
    assign clk_sel_o = sel_r;
    assign clk_div_o = div_r;

    // ******************************
    // checks
    // ******************************
    a_src_reset: assert property (@(posedge clk_i) src_rst |=> chip_rst_r)
        else $error("reset source did not assert chip reset");
    a_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(chip_rst_r) |-> $past(osc_ok_i) && $past(flash_init_done_i))
        else $error("reset released before ready");
    a_ds_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r == lpm_pkg::ST_DSLEEP |=> !clocks_en_o && pins_hold_o)
        else $error("clocks running in deep sleep");
    a_div_clear: assert property (@(posedge clk_i) disable iff (chip_rst_r)
        $rose(low) && st_r != lpm_pkg::ST_DPD |-> div_r == 8'h00 && !pll0_r)
        else $error("dividers not cleared on entry");
    a_ds_wake: assert property (@(posedge clk_i) disable iff (chip_rst_r)
        st_r == lpm_pkg::ST_DSLEEP && wake_irq |=> st_r == lpm_pkg::ST_RESUME)
        else $error("deep sleep missed wake");
    a_pd_power: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r == lpm_pkg::ST_PDOWN |=> !flash_pwr_o && !irc_pwr_o)
        else $error("power not removed in power-down");
    a_pd_sel: assert property (@(posedge clk_i) disable iff (chip_rst_r)
        $rose(st_r == lpm_pkg::ST_PDOWN) |-> sel_r == lpm_pkg::CLKSEL_RST)
        else $error("clock select not reset");
    a_dpd_exit: assert property (@(posedge clk_i) disable iff (chip_rst_r)
        st_r == lpm_pkg::ST_DPD && !rtc_alarm_i |=> st_r == lpm_pkg::ST_DPD)
        else $error("left deep power-down without alarm");
    a_flash_block: assert property (@(posedge clk_i) disable iff (rst_i)
        !flash_ok_r |=> !flash_access_o)
        else $error("flash access before timer expiry");
    a_prot_debug: assert property (@(posedge clk_i) disable iff (rst_i)
        prot_r != lpm_pkg::PROT_NONE |=> !dbg_allow_o)
        else $error("debug allowed under protection");
endmodule // lpm_ctrl

// File: verification/lpm_far_model.sv
// far side model: rc and main oscillator ticks, interrupt controller mask
`timescale 1ns/1ps
// ****************************************
// oscillator ticks and wake mask
// ****************************************
module lpm_far_model (
    input wire logic clk_i,
    input wire logic [15:0] irq_en_i,
    input wire logic [15:0] irq_prio_ok_i,
    output logic irc_tick_o,
    output logic osc_tick_o,
    output logic [15:0] irq_mask_o
);
    logic [1:0] div_r;
    initial begin
        div_r = 2'h0;
        irc_tick_o = 1'b0;
        osc_tick_o = 1'b0;
        irq_mask_o = 16'h0000;
    end
    // rc ticks at a quarter of the system clock, main oscillator every cycle
    always @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
        irc_tick_o <= (div_r == 2'h3);
        osc_tick_o <= 1'b1;
    end
    // only enabled interrupts of sufficient priority reach the wake unit
    always @(posedge clk_i) begin
        irq_mask_o <= irq_en_i & irq_prio_ok_i;
    end
endmodule // lpm_far_model

// File: verification/tb_top.sv
// self-checking testbench for the low power mode and reset controller
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAITF(c) begin for (wt = 0; wt < 20000 && !(c); wt++) @(negedge clk_i); \
    if (!(c)) begin errors++; final_report(); end end
module tb_top;
    // ****************************************
    // signals, far side and design
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, sleep_req_i = 1'b0, rtc_dpd_req_i = 1'b0, rtc_alarm_i = 1'b0;
    logic [15:0] irq_pend_i = 16'h0, irq_mask_i, irq_en = 16'h0002, irq_prio = 16'h0003;
    logic irc_tick_i, osc_tick_i, osc_ok_i = 1'b0, flash_init_done_i = 1'b0;
    logic [3:0] src = 4'h0;
    logic rst_pin_i, wdt_rst_i, por_i, bod_crit_i;
    logic bod_low_i = 1'b0, wdt_run_i = 1'b1, rtc_en_i = 1'b0;
    logic [1:0] prot_level_i = 2'h0, clk_sel_o, bl_cmdset_o;
    logic clocks_en_o, osc_en_o, irc_out_en_o, irc_pwr_o, flash_pwr_o, flash_access_o;
    logic core_pwr_o, pins_hold_o, cpu_run_o, wdt_keep_o, rtc_keep_o, pll0_en_o;
    logic pll1_en_o, pll_conn_o, chip_rst_o, bod_irq_o, dbg_allow_o, sector0_lock_o;
    logic override_pin_en_o;
    logic [7:0] clk_div_o;
    logic [31:0] boot_addr_o;
    logic [3:0] pexp [4] = '{4'b1001, 4'b0011, 4'b0101, 4'b0110};
    int errors = 0, n_checks = 0, irc_n = 0, osc_n = 0, i, wt, d, t0, t1;
    assign {bod_crit_i, por_i, wdt_rst_i, rst_pin_i} = src;
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        irc_n <= irc_n + int'(irc_tick_i);
        osc_n <= osc_n + int'(osc_tick_i);
    end
    lpm_far_model far_u (.clk_i, .irq_en_i(irq_en), .irq_prio_ok_i(irq_prio),
        .irc_tick_o(irc_tick_i), .osc_tick_o(osc_tick_i), .irq_mask_o(irq_mask_i));
    lpm_ctrl #(.NIRQ(16), .RST_HOLD(16), .IRC_START(4)) dut_u (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .sleep_req_i, .irq_pend_i, .irq_mask_i, .rtc_dpd_req_i, .rtc_alarm_i,
        .irc_tick_i, .osc_tick_i, .osc_ok_i, .flash_init_done_i, .rst_pin_i, .wdt_rst_i,
        .por_i, .bod_low_i, .bod_crit_i, .wdt_run_i, .rtc_en_i, .prot_level_i,
        .clocks_en_o, .osc_en_o, .irc_out_en_o, .irc_pwr_o, .flash_pwr_o,
        .flash_access_o, .core_pwr_o, .pins_hold_o, .cpu_run_o, .wdt_keep_o,
        .rtc_keep_o, .pll0_en_o, .pll1_en_o, .pll_conn_o, .clk_sel_o, .clk_div_o,
        .chip_rst_o, .boot_addr_o, .bod_irq_o, .dbg_allow_o, .bl_cmdset_o,
        .sector0_lock_o, .override_pin_en_o);
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw,
        input logic [3:0] s, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= dw;
        wb_sel_i <= s;
        r = 32'h0;
        // ack and read data are taken at the rising edge, before that edge updates them
        for (k = 0; k < 64; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) begin
                break;
            end
        end
        if (k == 64) begin
            errors++;
            final_report();
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic sleep_pulse();
        @(posedge clk_i) sleep_req_i <= 1'b1;
        @(posedge clk_i) sleep_req_i <= 1'b0;
        settle(3);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(40);
        `CHK(chip_rst_o, 1'b1)
        @(posedge clk_i) osc_ok_i <= 1'b1;
        settle(40);
        `CHK(chip_rst_o, 1'b1)
        @(posedge clk_i) flash_init_done_i <= 1'b1;
        `WAITF(chip_rst_o === 1'b0)
        `CHK(boot_addr_o, 32'h0000_0000)
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF, q);
        wb(1'b0, 8'h10, 32'h0, 4'hF, q);
        `CHK(q, 32'h0000_0000)
        wb(1'b1, 8'h0C, 32'h0000_000F, 4'hF, q);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i) src <= 4'h1 << i;
            settle(2);
            `CHK(chip_rst_o, 1'b1)
            @(posedge clk_i) src <= 4'h0;
            `WAITF(chip_rst_o === 1'b0)
            wb(1'b0, 8'h0C, 32'h0, 4'hF, q);
            `CHK(q[3:0], 4'h1 << i)
            wb(1'b1, 8'h0C, 32'h1 << i, 4'hF, q);
            wb(1'b0, 8'h0C, 32'h0, 4'hF, q);
            `CHK(q[3:0], 4'h0)
        end
        @(posedge clk_i) bod_low_i <= 1'b1;
        settle(2);
        `CHK(bod_irq_o, 1'b1)
        wb(1'b0, 8'h04, 32'h0, 4'hF, q);
        `CHK(q[7], 1'b1)
        @(posedge clk_i) bod_low_i <= 1'b0;
        settle(2);
        `CHK(bod_irq_o, 1'b0)
        for (i = 0; i < 2; i++) begin
            wb(1'b1, 8'h08, 32'h0000_1F55, 4'h1, q);
            wb(1'b0, 8'h08, 32'h0, 4'hF, q);
            `CHK(q[12:0], (i == 0) ? 13'h0000 : 13'h0300)
            wb(1'b1, 8'h08, 32'h0000_1F55, 4'h3, q);
            settle(1);
            `CHK({pll_conn_o, pll1_en_o, pll0_en_o, clk_sel_o, clk_div_o}, 13'h1F55)
            wb(1'b1, 8'h00, {29'h0, i[0], 2'h1}, 4'hF, q);
            sleep_pulse();
            `CHK({clocks_en_o, osc_en_o, irc_out_en_o, irc_pwr_o}, 4'h1)
            `CHK({flash_pwr_o, pins_hold_o, cpu_run_o}, 3'b110)
            `CHK({pll_conn_o, pll1_en_o, pll0_en_o, clk_div_o}, 11'h000)
            @(posedge clk_i) irq_en <= 16'h0000;
            irq_pend_i <= 16'h0001;
            settle(30);
            `CHK(cpu_run_o, 1'b0)
            @(posedge clk_i) irq_pend_i <= 16'h0003;
            t0 = irc_n;
            t1 = osc_n;
            `WAITF(cpu_run_o === 1'b1)
            d = (i == 0) ? irc_n - t0 : osc_n - t1;
            `CHK((i == 0) ? (d >= 4 && d <= 6) : (d >= 4096 && d <= 4100), 1'b1)
            `CHK({clocks_en_o, osc_en_o, irc_out_en_o, pins_hold_o}, {1'b1, i[0], 2'b10})
            @(posedge clk_i) irq_pend_i <= 16'h0000;
            irq_en <= 16'h0002;
        end
        wb(1'b1, 8'h00, 32'h0000_0002, 4'hF, q);
        sleep_pulse();
        `CHK({irc_pwr_o, flash_pwr_o, flash_access_o, clocks_en_o, osc_en_o}, 5'h00)
        `CHK({pll1_en_o, pll0_en_o, clk_sel_o, clk_div_o}, 12'h000)
        `CHK({wdt_keep_o, rtc_keep_o}, 2'b10)
        @(posedge clk_i) {wdt_run_i, rtc_en_i} <= 2'b01;
        settle(2);
        `CHK({wdt_keep_o, rtc_keep_o}, 2'b01)
        @(posedge clk_i) irq_pend_i <= 16'h0002;
        t0 = irc_n;
        `WAITF(cpu_run_o === 1'b1)
        `CHK(irc_n - t0 >= 4 && irc_n - t0 <= 7, 1'b1)
        `CHK({irc_pwr_o, flash_pwr_o, flash_access_o}, 3'b110)
        `WAITF(flash_access_o === 1'b1)
        `CHK(irc_n - t0 >= 1200 && irc_n - t0 <= 1204, 1'b1)
        @(posedge clk_i) irq_pend_i <= 16'h0000;
        rtc_dpd_req_i <= 1'b1;
        @(posedge clk_i) rtc_dpd_req_i <= 1'b0;
        settle(3);
        `CHK(core_pwr_o, 1'b0)
        @(posedge clk_i) irq_pend_i <= 16'h0003;
        settle(30);
        `CHK(core_pwr_o, 1'b0)
        @(posedge clk_i) rtc_alarm_i <= 1'b1;
        irq_pend_i <= 16'h0000;
        @(posedge clk_i) rtc_alarm_i <= 1'b0;
        `WAITF(cpu_run_o === 1'b1)
        `CHK(core_pwr_o, 1'b1)
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            prot_level_i <= i[1:0];
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            `WAITF(chip_rst_o === 1'b0)
            settle(1);
            `CHK({dbg_allow_o, bl_cmdset_o, override_pin_en_o}, pexp[i])
            if (i < 3) `CHK(sector0_lock_o, (i == 1))
        end
        final_report();
    end
endmodule // tb_top
